// ===== src/ssp_pkg.sv
// Package: register map, fields, reset values and state codes of the port
package ssp_pkg;
   // Register byte offsets
   localparam logic [4:0] ADDR_CTRL0 = 5'h00;
   localparam logic [4:0] ADDR_CTRL1 = 5'h04;
   localparam logic [4:0] ADDR_DATA = 5'h08;
   localparam logic [4:0] ADDR_STATUS = 5'h0c;
   localparam logic [4:0] ADDR_PRESCALE = 5'h10;
   // Status bit positions
   localparam int ST_TX_EMPTY = 0;
   localparam int ST_TX_NFULL = 1;
   localparam int ST_RX_NEMPTY = 2;
   localparam int ST_RX_FULL = 3;
   localparam int ST_BUSY = 4;
   localparam int ST_OVERRUN = 5;
   // Frame size limits, size field holds bits minus one
   localparam logic [3:0] DSS_MIN = 4'h3;
   localparam logic [3:0] DSS_RST = 4'h7;
   localparam logic [4:0] CMD_BITS = 5'h08;
   localparam logic [4:0] WORD_BITS = 5'h10;
   // Prescaler: even divisor, at least two
   localparam logic [7:0] CPS_RST = 8'h02;
   localparam logic [7:0] CPS_MIN = 8'h02;
   localparam logic [7:0] SCR_RST = 8'h00;

   typedef enum logic [1:0]
   {
      FMT_SPI = 2'h0,
      FMT_PULSE = 2'h1,
      FMT_CMD = 2'h2
   } ssp_fmt_t;

   typedef enum logic [1:0]
   {
      S_IDLE = 2'h0,
      S_LEAD = 2'h1,
      S_SHIFT = 2'h3,
      S_TAIL = 2'h2
   } ssp_state_t;

   typedef struct packed
   {
      logic [7:0] scr;
      logic cpha;
      logic cpol;
      logic [1:0] fmt;
      logic [3:0] dss;
   } ssp_ctrl0_t;

   typedef struct packed
   {
      logic sod;
      logic slave;
      logic enable;
      logic loopback;
   } ssp_ctrl1_t;
endpackage

// ===== src/ssp_fifo.sv
// First-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module ssp_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [W-1:0] i_data,
   // Drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [W-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   logic push;
   logic pop;

   assign o_ready = cnt_ff != (AW+1)'(DEPTH);
   assign o_valid = cnt_ff != '0;
   assign o_data = mem_ff[rd_ff];
   assign push = i_valid & o_ready;
   assign pop = o_valid & i_ready;

   always_ff @(posedge i_mclk)
   begin
      if (push)
         mem_ff[wr_ff] <= i_data;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         wr_ff <= wr_ff + AW'(push);
         rd_ff <= rd_ff + AW'(pop);
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_bound: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      cnt_ff <= (AW+1)'(DEPTH)) // R5
      else $error("fifo count above depth");
   a_fifo_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (o_valid && !i_ready) |=> o_valid && $stable(o_data)) // R5
      else $error("fifo head lost while stalled");
endmodule // ssp_fifo

// ===== src/ssp_top.sv
// Synchronous serial port: register slave, clock divider, shifter, buffers
// Contract
// [R1] Four wires: clock, frame select, data out, data in
// [R2] Three frame formats: SPI, pulse, command/response
// [R3] Frame length programmable from 4 to 16 bits
// [R4] Shift received bits in, serialise transmit words
// [R5] Separate eight-word, 16-bit transmit and receive buffers
// [R6] Configuration selects master or slave operation
// [R7] Slave may keep its data output undriven
// [R8] Master clock from prescaler then bit-rate divider
// [R9] Software keeps bit rate within peripheral limit
// [R10] Loopback routes transmit data to own receiver
// [R11] Master drives clock and frame; slave follows
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ssp_top #(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Avalon-MM register slave
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Serial link
   output logic o_sclk,
   output logic o_sclk_oe,
   input wire logic i_sclk,
   output logic o_fss,
   output logic o_fss_oe,
   input wire logic i_fss,
   output logic o_txd,
   output logic o_txd_oe,
   input wire logic i_rxd
);
   ssp_pkg::ssp_ctrl0_t ctrl0_ff;
   ssp_pkg::ssp_ctrl1_t ctrl1_ff;
   ssp_pkg::ssp_state_t state_ff;
   logic [7:0] cps_ff;
   logic rd_ack_ff;
   logic [31:0] rdata_ff;
   logic ovr_ff;
   logic data_sel;
   logic rd_take;
   logic wr_take;
   logic tx_in_ready;
   logic tx_valid;
   logic [15:0] tx_data;
   logic rxb_ready;
   logic rxb_valid;
   logic [15:0] rxb_data;
   logic rxq_ready;
   logic rx_valid;
   logic [15:0] rx_data;
   logic rx_pop;
   logic [3:0] dss;
   logic [4:0] nbits;
   logic [4:0] total;
   logic is_pulse;
   logic is_cmd;
   logic eff_cpol;
   logic eff_cpha;
   logic master;
   logic en;
   logic [6:0] p_cnt_ff;
   logic [7:0] s_cnt_ff;
   logic [6:0] half_cps;
   logic half_tick;
   logic [5:0] hcnt_ff;
   logic sclk_ff;
   logic fss_ff;
   logic [15:0] sh_ff;
   logic [15:0] rxsh_ff;
   logic [4:0] bitcnt_ff;
   logic first_ff;
   logic s_act_ff;
   logic sclk_q_ff;
   logic fss_q_ff;
   logic m_start;
   logic s_start;
   logic load;
   logic lead;
   logic trail;
   logic sample;
   logic shift;
   logic frame_done;
   logic rxd_eff;
   logic [15:0] word;

   // Register bus
   assign data_sel = i_avs_address == ssp_pkg::ADDR_DATA;
   assign o_avs_waitrequest = (i_avs_read & ~rd_ack_ff)
      | (i_avs_write & data_sel & ~tx_in_ready); // R5
   assign rd_take = i_avs_read & ~rd_ack_ff;
   assign wr_take = i_avs_write & ~o_avs_waitrequest;
   assign rx_pop = rd_take & data_sel & rx_valid;
   assign o_avs_readdata = rdata_ff;

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         rd_ack_ff <= 1'b0;
      else
         rd_ack_ff <= rd_take;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         rdata_ff <= '0;
      else if (rd_take)
      begin
         case (i_avs_address)
            ssp_pkg::ADDR_CTRL0: rdata_ff <= {16'h0000, ctrl0_ff};
            ssp_pkg::ADDR_CTRL1: rdata_ff <= {28'h0000000, ctrl1_ff};
            ssp_pkg::ADDR_DATA: rdata_ff <= {16'h0000, rx_valid ? rx_data
               : 16'h0000};
            ssp_pkg::ADDR_STATUS: rdata_ff <= {26'h0000000, ovr_ff,
               state_ff != ssp_pkg::S_IDLE || s_act_ff || tx_valid,
               ~rxq_ready, rx_valid, tx_in_ready, ~tx_valid};
            ssp_pkg::ADDR_PRESCALE: rdata_ff <= {24'h000000, cps_ff};
            default: rdata_ff <= '0;
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         ctrl0_ff <= '{scr: ssp_pkg::SCR_RST, cpha: 1'b0, cpol: 1'b0,
            fmt: ssp_pkg::FMT_SPI, dss: ssp_pkg::DSS_RST};
         ctrl1_ff <= '0;
         cps_ff <= ssp_pkg::CPS_RST;
      end
      else if (wr_take)
      begin
         if (i_avs_address == ssp_pkg::ADDR_CTRL0)
            ctrl0_ff <= i_avs_writedata[15:0];
         if (i_avs_address == ssp_pkg::ADDR_CTRL1)
            ctrl1_ff <= i_avs_writedata[3:0];
         if (i_avs_address == ssp_pkg::ADDR_PRESCALE)
            cps_ff <= i_avs_writedata[7:0];
      end
   end

   // Overrun flag: a new overrun wins over the clear
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
         ovr_ff <= 1'b0;
      else if (frame_done && !rxb_ready)
         ovr_ff <= 1'b1;
      else if (wr_take && i_avs_address == ssp_pkg::ADDR_STATUS
         && i_avs_writedata[ssp_pkg::ST_OVERRUN])
         ovr_ff <= 1'b0;
   end

   // Buffers: transmit queue, two-entry receive stage, receive queue
   ssp_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_txq (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_valid(wr_take & data_sel), .o_ready(tx_in_ready),
      .i_data(i_avs_writedata[15:0]),
      .o_valid(tx_valid), .i_ready(load & tx_valid), .o_data(tx_data)
   ); // R5
   ssp_fifo #(.W(16), .DEPTH(2)) u_rxb (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_valid(frame_done), .o_ready(rxb_ready), .i_data(word),
      .o_valid(rxb_valid), .i_ready(rxq_ready), .o_data(rxb_data)
   );
   ssp_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_rxq (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_valid(rxb_valid), .o_ready(rxq_ready), .i_data(rxb_data),
      .o_valid(rx_valid), .i_ready(rx_pop), .o_data(rx_data)
   ); // R5

   // Frame parameters
   assign dss = (ctrl0_ff.dss < ssp_pkg::DSS_MIN) ? ssp_pkg::DSS_MIN
      : ctrl0_ff.dss; // R3
   assign nbits = {1'b0, dss} + 5'h01; // R3
   assign is_pulse = ctrl0_ff.fmt == ssp_pkg::FMT_PULSE; // R2
   assign is_cmd = ctrl0_ff.fmt == ssp_pkg::FMT_CMD; // R2
   assign total = is_cmd ? nbits + ssp_pkg::CMD_BITS : nbits; // R2
   assign eff_cpol = (is_pulse || is_cmd) ? 1'b0 : ctrl0_ff.cpol;
   assign eff_cpha = is_pulse ? 1'b1 : (is_cmd ? 1'b0 : ctrl0_ff.cpha);
   assign master = ~ctrl1_ff.slave; // R6
   assign en = ctrl1_ff.enable;
   assign rxd_eff = ctrl1_ff.loopback ? sh_ff[15] : i_rxd; // R10

   // Bit-rate generator: prescaler then divider
   assign half_cps = (cps_ff < ssp_pkg::CPS_MIN) ? 7'h01 : cps_ff[7:1];
   assign half_tick = (p_cnt_ff == half_cps - 7'h01)
      && (s_cnt_ff == ctrl0_ff.scr); // R8

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst || state_ff == ssp_pkg::S_IDLE)
      begin
         p_cnt_ff <= '0;
         s_cnt_ff <= '0;
      end
      else if (p_cnt_ff == half_cps - 7'h01)
      begin
         p_cnt_ff <= '0;
         s_cnt_ff <= (s_cnt_ff == ctrl0_ff.scr) ? 8'h00
            : s_cnt_ff + 8'h01; // R8
      end
      else
         p_cnt_ff <= p_cnt_ff + 7'h01; // R8
   end

   // Master frame sequencer
   assign m_start = en & master & tx_valid & rxb_ready
      & (state_ff == ssp_pkg::S_IDLE); // R6

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         state_ff <= ssp_pkg::S_IDLE;
         hcnt_ff <= '0;
         sclk_ff <= 1'b0;
         fss_ff <= 1'b1;
      end
      else
      begin
         case (state_ff)
            ssp_pkg::S_IDLE:
            begin
               sclk_ff <= eff_cpol; // R11
               fss_ff <= ~is_pulse; // R11
               hcnt_ff <= '0;
               if (m_start)
               begin
                  state_ff <= ssp_pkg::S_LEAD;
                  fss_ff <= is_pulse; // R2
               end
            end
            ssp_pkg::S_LEAD:
               if (half_tick)
               begin
                  if (is_pulse)
                     sclk_ff <= ~sclk_ff;
                  if (is_pulse && hcnt_ff == 6'h00)
                     hcnt_ff <= 6'h01;
                  else
                  begin
                     hcnt_ff <= '0;
                     fss_ff <= 1'b0; // R2
                     state_ff <= ssp_pkg::S_SHIFT;
                  end
               end
            ssp_pkg::S_SHIFT:
               if (half_tick)
               begin
                  sclk_ff <= ~sclk_ff; // R11
                  hcnt_ff <= hcnt_ff + 6'h01;
                  if (hcnt_ff == {total, 1'b0} - 6'h01)
                     state_ff <= ssp_pkg::S_TAIL;
               end
            ssp_pkg::S_TAIL:
               if (half_tick)
               begin
                  fss_ff <= ~is_pulse;
                  state_ff <= ssp_pkg::S_IDLE;
               end
            default: state_ff <= ssp_pkg::S_IDLE;
         endcase
      end
   end

   // Slave frame tracking on the sampled external clock
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         sclk_q_ff <= 1'b0;
         fss_q_ff <= 1'b1;
      end
      else
      begin
         sclk_q_ff <= i_sclk;
         fss_q_ff <= i_fss;
      end
   end

   assign s_start = en & ~master & ~s_act_ff & (is_pulse
      ? (i_fss & ~i_sclk & sclk_q_ff) : (fss_q_ff & ~i_fss)); // R11

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst || master || !en)
         s_act_ff <= 1'b0;
      else if (s_start)
         s_act_ff <= 1'b1;
      else if (frame_done || (!is_pulse && i_fss))
         s_act_ff <= 1'b0;
   end

   // Edge classification and shift engine
   always_comb
   begin
      if (master)
      begin
         lead = (state_ff == ssp_pkg::S_SHIFT) & half_tick
            & (sclk_ff == eff_cpol);
         trail = (state_ff == ssp_pkg::S_SHIFT) & half_tick
            & (sclk_ff != eff_cpol);
      end
      else
      begin
         lead = s_act_ff & (i_sclk != sclk_q_ff) & (sclk_q_ff == eff_cpol);
         trail = s_act_ff & (i_sclk != sclk_q_ff) & (sclk_q_ff != eff_cpol);
      end
   end

   assign load = m_start | s_start;
   assign sample = eff_cpha ? trail : lead; // R11
   assign shift = eff_cpha ? (lead & ~first_ff) : trail; // R11
   assign frame_done = sample & (bitcnt_ff == total - 5'h01); // R4
   assign word = {rxsh_ff[14:0], rxd_eff}; // R4

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         sh_ff <= '0;
         rxsh_ff <= '0;
         bitcnt_ff <= '0;
         first_ff <= 1'b0;
      end
      else if (load)
      begin
         if (!tx_valid)
            sh_ff <= '0;
         else if (is_cmd)
            sh_ff <= {tx_data[7:0], 8'h00}; // R2
         else
            sh_ff <= tx_data << (ssp_pkg::WORD_BITS - nbits); // R4
         rxsh_ff <= '0;
         bitcnt_ff <= '0;
         first_ff <= 1'b1;
      end
      else
      begin
         if (lead)
            first_ff <= 1'b0;
         if (shift)
            sh_ff <= {sh_ff[14:0], 1'b0}; // R4
         if (sample)
         begin
            bitcnt_ff <= bitcnt_ff + 5'h01;
            if (!is_cmd || bitcnt_ff >= ssp_pkg::CMD_BITS)
               rxsh_ff <= word; // R4
         end
      end
   end

   // Link pins
   assign o_sclk = sclk_ff; // R1
   assign o_sclk_oe = en & master; // R11
   assign o_fss = fss_ff; // R1
   assign o_fss_oe = en & master; // R11
   assign o_txd = sh_ff[15]; // R1
   assign o_txd_oe = en & (master | (s_act_ff & ~ctrl1_ff.sod)); // R7

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   a_wait_full: assert property ((i_avs_write && data_sel && !tx_in_ready)
      |-> o_avs_waitrequest) // R5
      else $error("write to full transmit queue not stalled");
   a_start_lead: assert property (m_start |=> state_ff == ssp_pkg::S_LEAD
      && o_fss == is_pulse) // R6
      else $error("master start did not open a frame");
   a_sclk_idle: assert property ((state_ff == ssp_pkg::S_IDLE
      && $past(state_ff) == ssp_pkg::S_IDLE && $stable(eff_cpol))
      |-> o_sclk == eff_cpol) // R11
      else $error("idle clock level wrong");
   a_fss_shift: assert property ((master && state_ff == ssp_pkg::S_SHIFT)
      |-> !o_fss) // R2
      else $error("frame select wrong during shift");
   a_sod_quiet: assert property ((ctrl1_ff.slave && ctrl1_ff.sod)
      |-> !o_txd_oe) // R7
      else $error("slave drives data while disabled");
   a_loop_back: assert property (ctrl1_ff.loopback |-> rxd_eff == o_txd) // R10
      else $error("loopback path broken");
   a_frame_len: assert property (nbits >= 5'h04 && nbits <= 5'h10) // R3
      else $error("frame length out of range");
   a_master_room: assert property ((master && frame_done) |-> rxb_ready) // R4
      else $error("master frame finished without buffer room");
   a_rate_wrap: assert property ((half_tick && state_ff != ssp_pkg::S_IDLE)
      |=> p_cnt_ff == 7'h00 && s_cnt_ff == 8'h00) // R8
      else $error("divider did not restart after tick");
   a_ovr_sticky: assert property ((ovr_ff && !wr_take) |=> ovr_ff) // R5
      else $error("overrun flag lost");

   c_spi_frame: cover property (master && frame_done
      && ctrl0_ff.fmt == ssp_pkg::FMT_SPI);
   c_pulse_frame: cover property (master && frame_done && is_pulse);
   c_cmd_frame: cover property (master && frame_done && is_cmd);
   c_slave_frame: cover property (!master && frame_done);
   c_overrun: cover property (frame_done && !rxb_ready);
endmodule // ssp_top

// ===== verif/ssp_peer.sv
// Peripheral model: mode 0 serial slave answering the port's master frames
`timescale 1ns/1ps
module ssp_peer (
   // Clock
   input wire logic i_mclk,
   // Serial link
   input wire logic i_sclk,
   input wire logic i_fss,
   input wire logic i_txd,
   output logic o_rxd,
   // Frame setup and result
   input wire logic [15:0] i_reply,
   input wire logic [4:0] i_bits,
   output logic [15:0] o_word
);
   logic [15:0] shift_ff;
   logic tog_ff = 1'b0;
   // Released line toggles, so a stale bit is never read as data
   assign o_rxd = i_fss ? tog_ff : shift_ff[15];
   always @(posedge i_mclk)
      tog_ff <= ~tog_ff;
   always @(negedge i_fss)
      shift_ff <= i_reply << (5'd16 - i_bits);
   always @(posedge i_sclk)
      if (!i_fss)
         o_word <= {o_word[14:0], i_txd};
   always @(negedge i_sclk)
      if (!i_fss)
         shift_ff <= shift_ff << 1;
endmodule // ssp_peer

// ===== verif/tb_top.sv
// Testbench: registers, master frames, buffers, loopback, slave frames
`timescale 1ns/1ps
module tb_top;
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [4:0] avs_addr = 5'h00;
   logic avs_rd = 1'b0;
   logic avs_wr = 1'b0;
   logic [31:0] avs_wd = 32'h0;
   logic [31:0] rdata;
   logic wreq, sclk, sclk_oe, fss, fss_oe, txd, txd_oe, peer_rxd;
   logic slv = 1'b0;
   logic tb_sclk = 1'b0;
   logic tb_fss = 1'b1;
   logic tb_rxd = 1'b0;
   logic tog = 1'b0;
   logic sclk_q = 1'b0;
   logic [15:0] peer_reply = 16'h0;
   logic [4:0] peer_bits = 5'h08;
   logic [15:0] peer_word;
   int fail_count = 0;
   int n_checks = 0;
   int fss_hi = 0;
   int fss_lo = 0;
   int sclk_hi = 0;
   int sclk_rise = 0;
   wire logic pin_sclk = sclk_oe ? sclk : tb_sclk;
   wire logic pin_fss = fss_oe ? fss : tb_fss;
   wire logic pin_rxd = slv ? (tb_fss ? tog : tb_rxd) : peer_rxd;

   always #2.5 i_mclk = ~i_mclk;

   always @(posedge i_mclk)
   begin
      tog <= ~tog;
      sclk_q <= sclk;
      if (fss_oe === 1'b1 && fss === 1'b1) fss_hi++;
      if (fss_oe === 1'b1 && fss === 1'b0) fss_lo++;
      if (sclk === 1'b1) sclk_hi++;
      if (sclk === 1'b1 && sclk_q === 1'b0) sclk_rise++;
   end

   ssp_top #(.FIFO_DEPTH(8)) i_ssp_top (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_avs_address(avs_addr), .i_avs_read(avs_rd),
      .i_avs_write(avs_wr), .i_avs_writedata(avs_wd),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .o_sclk(sclk), .o_sclk_oe(sclk_oe), .i_sclk(pin_sclk),
      .o_fss(fss), .o_fss_oe(fss_oe), .i_fss(pin_fss),
      .o_txd(txd), .o_txd_oe(txd_oe), .i_rxd(pin_rxd));

   ssp_peer i_ssp_peer (
      .i_mclk(i_mclk), .i_sclk(pin_sclk), .i_fss(pin_fss), .i_txd(txd),
      .o_rxd(peer_rxd), .i_reply(peer_reply), .i_bits(peer_bits),
      .o_word(peer_word));

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic avs(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_mclk);
      avs_addr <= a;
      avs_wr <= wr;
      avs_rd <= ~wr;
      avs_wd <= d;
      @(posedge i_mclk);
      while (wreq !== 1'b0 && n < 2000)
      begin
         n++;
         @(posedge i_mclk);
      end
      if (n >= 2000)
      begin
         chk("bus answer", 32'h0, 32'h1);
         finish_test();
      end
      q = rdata;
      avs_wr <= 1'b0;
      avs_rd <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      avs(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      avs(1'b0, a, 32'h0, q);
   endtask

   task automatic wait_done(input logic full);
      logic [31:0] s;
      int n;
      n = 0;
      do
      begin
         rd(ssp_pkg::ADDR_STATUS, s);
         n++;
      end while (n < 500 && (s[ssp_pkg::ST_BUSY] !== 1'b0 ||
         s[ssp_pkg::ST_RX_NEMPTY] !== 1'b1 ||
         (full && s[ssp_pkg::ST_RX_FULL] !== 1'b1)));
      if (n >= 500)
      begin
         chk("frame done", 32'h1, 32'h0);
         finish_test();
      end
   endtask

   task automatic t_reset_regs();
      logic [31:0] q;
      rd(ssp_pkg::ADDR_CTRL0, q);
      chk("ctrl0 reset", 32'h0000_0007, q);
      rd(ssp_pkg::ADDR_CTRL1, q);
      chk("ctrl1 reset", 32'h0000_0000, q);
      rd(ssp_pkg::ADDR_PRESCALE, q);
      chk("prescale reset", 32'h0000_0002, q);
      rd(ssp_pkg::ADDR_STATUS, q);
      chk("status reset", 32'h0000_0003, q);
      wr(5'h14, 32'hffff_ffff);
      rd(5'h14, q);
      chk("unmapped", 32'h0000_0000, q);
      wr(ssp_pkg::ADDR_CTRL0, 32'h0000_0000);
      rd(ssp_pkg::ADDR_CTRL0, q);
      chk("size floor", 32'h0000_0000, q);
      wr(ssp_pkg::ADDR_CTRL0, 32'hffff_ab6f);
      rd(ssp_pkg::ADDR_CTRL0, q);
      chk("ctrl0 fields", 32'h0000_ab6f, q);
   endtask

   task automatic t_master(input ssp_pkg::ssp_fmt_t fmt, input int n,
                           input int cps, input int scr,
                           input logic [15:0] tx, input logic [15:0] rep);
      logic [31:0] q;
      logic [15:0] m;
      int half, h0, l0, s0, r0;
      m = 16'hffff >> (16 - n);
      half = (cps / 2) * (scr + 1);
      slv <= 1'b0;
      peer_reply <= rep;
      peer_bits <= 5'(n);
      wr(ssp_pkg::ADDR_PRESCALE, 32'(cps));
      wr(ssp_pkg::ADDR_CTRL0, {16'h0, 8'(scr), 2'b00, fmt, 4'(n - 1)});
      wr(ssp_pkg::ADDR_CTRL1, 32'h0000_0002);
      h0 = fss_hi;
      l0 = fss_lo;
      s0 = sclk_hi;
      r0 = sclk_rise;
      wr(ssp_pkg::ADDR_DATA, {16'h0, tx});
      wait_done(1'b0);
      rd(ssp_pkg::ADDR_DATA, q);
      if (fmt == ssp_pkg::FMT_SPI)
      begin
         chk("rx word", {16'h0, rep & m}, q);
         chk("peer word", {16'h0, tx & m}, {16'h0, peer_word & m});
         chk("fss low", (2 * n + 2) * half, fss_lo - l0);
         chk("sclk rises", n, sclk_rise - r0);
         chk("sclk high", n * half, sclk_hi - s0);
      end
      else if (fmt == ssp_pkg::FMT_PULSE)
         chk("fss pulse", 2 * half, fss_hi - h0);
      else
         chk("cmd rises", 8 + n, sclk_rise - r0);
   endtask

   task automatic t_fifo_loop();
      logic [31:0] q;
      wr(ssp_pkg::ADDR_CTRL1, 32'h0000_0000);
      wr(ssp_pkg::ADDR_CTRL0, 32'h0000_00cf);
      for (int i = 0; i < 8; i++)
         wr(ssp_pkg::ADDR_DATA, {16'h0, 16'h8001 + 16'(i) * 16'h1111});
      rd(ssp_pkg::ADDR_STATUS, q);
      chk("tx full status", 32'h0000_0010, q);
      wr(ssp_pkg::ADDR_CTRL1, 32'h0000_0003);
      wait_done(1'b1);
      rd(ssp_pkg::ADDR_STATUS, q);
      chk("rx full status", 32'h0000_000f, q);
      for (int i = 0; i < 8; i++)
      begin
         rd(ssp_pkg::ADDR_DATA, q);
         chk("loop word", {16'h0, 16'h8001 + 16'(i) * 16'h1111}, q);
      end
      rd(ssp_pkg::ADDR_DATA, q);
      chk("empty read", 32'h0000_0000, q);
   endtask

   task automatic t_slave(input logic sod, input logic [7:0] tx,
                          input logic [7:0] din);
      logic [31:0] q;
      logic [7:0] got;
      slv <= 1'b1;
      wr(ssp_pkg::ADDR_CTRL0, 32'h0000_0007);
      wr(ssp_pkg::ADDR_CTRL1, {28'h0, sod, 3'b110});
      wr(ssp_pkg::ADDR_DATA, {24'h0, tx});
      chk("sclk oe", 32'h0, {31'h0, sclk_oe});
      chk("fss oe", 32'h0, {31'h0, fss_oe});
      tb_fss <= 1'b0;
      repeat (4) @(posedge i_mclk);
      for (int i = 7; i >= 0; i--)
      begin
         tb_rxd <= din[i];
         repeat (4) @(posedge i_mclk);
         got[i] = txd;
         chk("txd drive", {31'h0, ~sod}, {31'h0, txd_oe});
         tb_sclk <= 1'b1;
         repeat (4) @(posedge i_mclk);
         tb_sclk <= 1'b0;
      end
      repeat (4) @(posedge i_mclk);
      tb_fss <= 1'b1;
      wait_done(1'b0);
      rd(ssp_pkg::ADDR_DATA, q);
      chk("slave rx", {24'h0, din}, q);
      if (!sod) chk("slave tx", {24'h0, tx}, {24'h0, got});
   endtask

   initial
   begin
      repeat (12) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      t_reset_regs();
      t_master(ssp_pkg::FMT_SPI, 4, 2, 0, 16'h000a, 16'h0005);
      t_master(ssp_pkg::FMT_SPI, 16, 4, 1, 16'hc3a5, 16'h5a3c);
      t_master(ssp_pkg::FMT_SPI, 8, 6, 0, 16'h0069, 16'h00b2);
      t_master(ssp_pkg::FMT_PULSE, 8, 4, 1, 16'h0033, 16'h0000);
      t_master(ssp_pkg::FMT_CMD, 8, 4, 1, 16'h00a1, 16'h0000);
      t_fifo_loop();
      t_slave(1'b0, 8'h96, 8'h3c);
      t_slave(1'b1, 8'h5a, 8'hc1);
      finish_test();
   end

   initial
   begin
      #400000;
      fail_count++;
      $display("Watchdog expired");
      finish_test();
   end
endmodule // tb_top
